// ### rtl/eac_pkg.sv
// constants shared by both ends of the eeprom access controller
package eac_pkg;

  // ----------------------------------------------------------------
  // address map of the device, in io address space
  // ----------------------------------------------------------------
  localparam logic [5:0] IO_ADDR_LOW = 6'h21;
  localparam logic [5:0] IO_ADDR_HIGH = 6'h22;
  localparam logic [5:0] IO_DATA = 6'h20;
  localparam logic [5:0] IO_CTRL = 6'h1F;
  localparam logic [5:0] IO_FLASH = 6'h1D;
  localparam logic [5:0] IO_EVENT = 6'h1C;
  localparam logic [7:0] DATA_SPACE_OFS = 8'h20;
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] DATA_IO_TOP = 8'h5F;
  localparam logic [7:0] EXT_IO_LOW = 8'h60;
  localparam logic [5:0] BIT_OP_TOP = 6'h1F;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_RIE = 3;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_READ = 0;
  localparam int EVENT_DONE = 0;
  localparam int FLASH_BUSY = 0;
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // sizes, reset values and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int TIMER_W = 18;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ATOMIC_NS = 3_400_000;
  localparam int T_SPLIT_NS = 1_800_000;
  localparam int ATOMIC_CYCLES = (T_ATOMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPLIT_CYCLES = (T_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_WRITE_CYCLES = 26_368;

  // ----------------------------------------------------------------
  // host command registers
  // ----------------------------------------------------------------
  localparam logic [1:0] HOST_ADDR = 2'h0;
  localparam logic [1:0] HOST_DATA = 2'h1;
  localparam logic [1:0] HOST_CTRL = 2'h2;
  localparam logic [1:0] HOST_RESULT = 2'h3;
  localparam int HC_GO_WRITE = 0;
  localparam int HC_GO_READ = 1;
  localparam int HC_MODE_LO = 2;
  localparam int HC_RIE = 4;
  localparam int HC_GIE = 5;
  localparam int HC_CORE_RESET = 6;
  localparam int HS_BUSY = 0;
  localparam int HS_IRQ = 1;

endpackage

// ### rtl/eac_if.sv
// io bus between the cpu side and the eeprom access controller
`timescale 1ns/1ps
interface eac_if;
  logic [7:0] addr;
  logic io_space;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic bset;
  logic bclr;
  logic [2:0] bit_idx;
  logic gie;
  logic core_reset;
  logic [7:0] rdata;
  logic stall;
  logic ready_irq;

  modport dev (
    input addr, io_space, wdata, we, re, bset, bclr, bit_idx, gie, core_reset,
    output rdata, stall, ready_irq
  );
  modport host (
    output addr, io_space, wdata, we, re, bset, bclr, bit_idx, gie, core_reset,
    input rdata, stall, ready_irq
  );
endinterface

// ### rtl/eac_dev.sv
// eeprom access controller: io registers, array and programming timer
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module eac_dev
  import eac_pkg::*;
#(
  parameter int ATOMIC_CYC = ATOMIC_CYCLES,
  parameter int SPLIT_CYC = SPLIT_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  eac_if.dev BUS,
  input wire logic FLASH_SELFPROG_BUSY,
  output logic PROG_ACTIVE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [1:0] mode;
    logic rie;
    logic arm;
    logic [2:0] arm_cnt;
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdat;
    logic [1:0] wmode;
    logic [2:0] stall_cnt;
    logic stall;
    logic done;
    logic [7:0] rdata;
    logic irq;
  } eac_dev_s;

  eac_dev_s s;
  eac_dev_s next_s;

  // the array is not reset: it models nonvolatile cells
  logic [7:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd;

  logic hit;
  logic bit_op;
  logic wr;
  logic [5:0] ioa;
  logic [7:0] mask;
  logic [7:0] cur;
  logic [7:0] base;
  logic [7:0] wv;

  assign mem_rd = mem[s.addr];

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_view(input logic [5:0] a, input eac_dev_s st,
                                          input logic fl);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      IO_ADDR_LOW: v = st.addr[7:0];
      IO_ADDR_HIGH: v = {7'h00, st.addr[8]};
      IO_DATA: v = st.data;
      IO_CTRL: v = {2'b00, st.mode, st.rie, st.arm, st.busy, 1'b0};
      IO_EVENT: v = {7'h00, st.done};
      IO_FLASH: v = {7'h00, fl};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_wd = BYTE_RESET;

    // io instructions see 0x00..0x3F; loads and stores see the same
    // registers shifted by 0x20, up to 0x5F; extended space from 0x60 is not decoded
    if (BUS.io_space) begin
      hit = (BUS.addr <= IO_TOP);
      ioa = BUS.addr[5:0];
    end else begin
      hit = (BUS.addr >= DATA_SPACE_OFS) && (BUS.addr <= DATA_IO_TOP);
      ioa = 6'(BUS.addr - DATA_SPACE_OFS);
    end

    cur = reg_view(ioa, s, FLASH_SELFPROG_BUSY);
    mask = 8'h01 << BUS.bit_idx;
    bit_op = (BUS.bset || BUS.bclr) && BUS.io_space && hit && (ioa <= BIT_OP_TOP);

    // a bit op rewrites only the named bit: one-to-clear flags and the
    // action bits are taken as zero so they are not fired again
    if (ioa == IO_EVENT) begin
      base = 8'h00;
    end else if (ioa == IO_CTRL) begin
      base = cur & ~8'h07;
    end else begin
      base = cur;
    end
    wv = BUS.bset ? (base | mask) : (base & ~mask);
    if (BUS.we) begin
      wv = BUS.wdata;
    end
    wr = (BUS.we && hit) || bit_op;

    next_s.rdata = (BUS.re && hit) ? cur : BYTE_RESET;

    if (s.arm_cnt != 3'h0) begin
      next_s.arm_cnt = s.arm_cnt - 3'h1;
      if (s.arm_cnt == 3'h1) begin
        next_s.arm = 1'b0;
      end
    end
    if (s.stall_cnt != 3'h0) begin
      next_s.stall_cnt = s.stall_cnt - 3'h1;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr) begin
      unique case (ioa)
        IO_ADDR_LOW: begin
          if (!s.busy) begin
            next_s.addr[7:0] = wv;
          end
        end
        IO_ADDR_HIGH: begin
          if (!s.busy) begin
            next_s.addr[8] = wv[0];
          end
        end
        IO_DATA: next_s.data = wv;
        IO_CTRL: begin
          if (!s.busy) begin
            next_s.mode = wv[CTRL_MODE_LO +: 2];
          end
          next_s.rie = wv[CTRL_RIE];
          if (wv[CTRL_ARM]) begin
            next_s.arm = 1'b1;
            next_s.arm_cnt = ARM_CYCLES;
          end
          // strobe uses the mode already held, so mode must be set
          // no later than the arm write
          if (wv[CTRL_STROBE] && s.arm && !s.busy && !FLASH_SELFPROG_BUSY
              && s.mode != MODE_RESERVED) begin
            next_s.busy = 1'b1;
            next_s.timer = (s.mode == MODE_ATOMIC) ? TIMER_W'(ATOMIC_CYC)
                                                   : TIMER_W'(SPLIT_CYC);
            next_s.waddr = s.addr;
            next_s.wdat = s.data;
            next_s.wmode = s.mode;
            next_s.arm = 1'b0;
            next_s.arm_cnt = 3'h0;
            next_s.stall_cnt = WRITE_STALL;
          end
          if (wv[CTRL_READ] && !s.busy) begin
            next_s.data = mem_rd;
            next_s.stall_cnt = READ_STALL;
          end
        end
        IO_EVENT: begin
          if (wv[EVENT_DONE]) begin
            next_s.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // core reset: a running write is left to finish
    // ----------------------------------------------------------------
    if (BUS.core_reset) begin
      next_s.addr = ADDR_RESET;
      next_s.data = BYTE_RESET;
      next_s.rie = 1'b0;
      next_s.arm = 1'b0;
      next_s.arm_cnt = 3'h0;
      next_s.stall_cnt = 3'h0;
      next_s.done = 1'b0;
      next_s.rdata = BYTE_RESET;
      if (!s.busy) begin
        next_s.mode = MODE_ATOMIC;
      end
    end

    // ----------------------------------------------------------------
    // programming timer; completion sets done after any clear above
    // ----------------------------------------------------------------
    if (s.busy) begin
      if (s.timer <= TIMER_W'(1)) begin
        next_s.busy = 1'b0;
        next_s.timer = '0;
        next_s.done = 1'b1;
        mem_we = (s.wmode != MODE_RESERVED);
        unique case (s.wmode)
          MODE_ATOMIC: mem_wd = s.wdat;
          MODE_ERASE: mem_wd = ERASED_BYTE;
          MODE_WRITE: mem_wd = mem[s.waddr] & s.wdat;
          MODE_RESERVED: mem_wd = BYTE_RESET;
        endcase
      end else begin
        next_s.timer = s.timer - TIMER_W'(1);
      end
    end

    next_s.stall = (next_s.stall_cnt != 3'h0);
    next_s.irq = next_s.rie && BUS.gie && !next_s.busy && !FLASH_SELFPROG_BUSY;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      mem[s.waddr] <= mem_wd;
    end
  end

  assign BUS.rdata = s.rdata;
  assign BUS.stall = s.stall;
  assign BUS.ready_irq = s.irq;
  assign PROG_ACTIVE = s.busy;

endmodule

// ### rtl/eac_host.sv
// cpu side: runs eeprom read and write sequences on command
`timescale 1ns/1ps
module eac_host
  import eac_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  eac_if.host BUS,
  input wire logic [1:0] SW_ADDR,
  input wire logic [15:0] SW_WDATA,
  input wire logic SW_WE,
  input wire logic SW_RE,
  output logic [15:0] SW_RDATA
);

  typedef enum logic [3:0] {
    H_IDLE, H_POLL, H_CHECK, H_FPOLL, H_FCHECK, H_ADDR_HI, H_ADDR_LO,
    H_DATA, H_ARM, H_STROBE, H_READ, H_FETCH, H_CAPTURE
  } eac_hstate_e;

  typedef struct packed {
    eac_hstate_e st;
    logic gap;
    logic rd_pend;
    logic is_write;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [1:0] mode;
    logic rie;
    logic gie;
    logic [7:0] last;
    logic [7:0] result;
    logic [7:0] b_addr;
    logic b_io;
    logic [7:0] b_wdata;
    logic b_we;
    logic b_re;
    logic b_bset;
    logic [2:0] b_idx;
    logic b_gie;
    logic b_core;
    logic [15:0] sw_rdata;
  } eac_host_s;

  eac_host_s s;
  eac_host_s next_s;

  // ----------------------------------------------------------------
  // sequencer: every access is followed by at least one quiet cycle so
  // that a stall raised by the device is seen before the next access
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.b_we = 1'b0;
    next_s.b_re = 1'b0;
    next_s.b_bset = 1'b0;
    next_s.b_core = 1'b0;
    next_s.sw_rdata = 16'h0000;

    if (s.gap) begin
      // read data stand only in the cycle after the read, so a read keeps
      // the gap one more cycle and takes the byte at its end
      next_s.last = BUS.rdata;
      if (s.rd_pend) begin
        next_s.rd_pend = 1'b0;
      end else begin
        next_s.gap = 1'b0;
      end
    end else if (!BUS.stall) begin
      unique case (s.st)
        H_IDLE: begin
        end
        H_POLL: begin
          next_s.b_re = 1'b1;
          next_s.b_io = 1'b0;
          next_s.b_addr = 8'({2'b00, IO_CTRL}) + DATA_SPACE_OFS;
          next_s.st = H_CHECK;
        end
        H_CHECK: begin
          if (s.last[CTRL_STROBE]) begin
            next_s.st = H_POLL;
          end else begin
            next_s.st = s.is_write ? H_FPOLL : H_ADDR_HI;
          end
        end
        H_FPOLL: begin
          next_s.b_re = 1'b1;
          next_s.b_io = 1'b1;
          next_s.b_addr = {2'b00, IO_FLASH};
          next_s.st = H_FCHECK;
        end
        H_FCHECK: begin
          next_s.st = s.last[FLASH_BUSY] ? H_FPOLL : H_ADDR_HI;
        end
        H_ADDR_HI: begin
          next_s.b_we = 1'b1;
          next_s.b_io = 1'b1;
          next_s.b_addr = {2'b00, IO_ADDR_HIGH};
          next_s.b_wdata = {7'h00, s.addr[8]};
          next_s.st = H_ADDR_LO;
        end
        H_ADDR_LO: begin
          next_s.b_we = 1'b1;
          next_s.b_addr = {2'b00, IO_ADDR_LOW};
          next_s.b_wdata = s.addr[7:0];
          next_s.st = s.is_write ? H_DATA : H_READ;
        end
        H_DATA: begin
          next_s.b_we = 1'b1;
          next_s.b_addr = {2'b00, IO_DATA};
          next_s.b_wdata = s.data;
          next_s.st = H_ARM;
        end
        H_ARM: begin
          next_s.b_we = 1'b1;
          next_s.b_addr = {2'b00, IO_CTRL};
          next_s.b_wdata = {2'b00, s.mode, s.rie, 1'b1, 2'b00};
          next_s.st = H_STROBE;
        end
        H_STROBE: begin
          next_s.b_bset = 1'b1;
          next_s.b_addr = {2'b00, IO_CTRL};
          next_s.b_idx = 3'(CTRL_STROBE);
          next_s.st = H_IDLE;
        end
        H_READ: begin
          next_s.b_bset = 1'b1;
          next_s.b_addr = {2'b00, IO_CTRL};
          next_s.b_idx = 3'(CTRL_READ);
          next_s.st = H_FETCH;
        end
        H_FETCH: begin
          next_s.b_re = 1'b1;
          next_s.b_addr = {2'b00, IO_DATA};
          next_s.st = H_CAPTURE;
        end
        H_CAPTURE: begin
          next_s.result = s.last;
          next_s.st = H_IDLE;
        end
      endcase
      if (next_s.b_we || next_s.b_re || next_s.b_bset) begin
        next_s.gap = 1'b1;
        next_s.rd_pend = next_s.b_re;
      end
    end

    // ----------------------------------------------------------------
    // command registers
    // ----------------------------------------------------------------
    if (SW_WE) begin
      unique case (SW_ADDR)
        HOST_ADDR: next_s.addr = SW_WDATA[ADDR_W-1:0];
        HOST_DATA: next_s.data = SW_WDATA[7:0];
        HOST_CTRL: begin
          next_s.mode = SW_WDATA[HC_MODE_LO +: 2];
          next_s.rie = SW_WDATA[HC_RIE];
          next_s.gie = SW_WDATA[HC_GIE];
          next_s.b_core = SW_WDATA[HC_CORE_RESET];
          if (s.st == H_IDLE && (SW_WDATA[HC_GO_WRITE] || SW_WDATA[HC_GO_READ])) begin
            next_s.is_write = SW_WDATA[HC_GO_WRITE];
            next_s.st = H_POLL;
          end
        end
        HOST_RESULT: begin
        end
      endcase
    end
    if (SW_RE) begin
      unique case (SW_ADDR)
        HOST_ADDR: next_s.sw_rdata = 16'(s.addr);
        HOST_DATA: next_s.sw_rdata = {8'h00, s.data};
        HOST_CTRL: next_s.sw_rdata = {10'h000, s.gie, s.rie, s.mode,
                                      BUS.ready_irq, s.st != H_IDLE};
        HOST_RESULT: next_s.sw_rdata = {8'h00, s.result};
      endcase
    end

    // global interrupts stay off for the whole sequence except the strobe, which goes out with them on
    next_s.b_gie = next_s.gie && (next_s.st == H_IDLE);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign BUS.addr = s.b_addr;
  assign BUS.io_space = s.b_io;
  assign BUS.wdata = s.b_wdata;
  assign BUS.we = s.b_we;
  assign BUS.re = s.b_re;
  assign BUS.bset = s.b_bset;
  assign BUS.bclr = 1'b0;
  assign BUS.bit_idx = s.b_idx;
  assign BUS.gie = s.b_gie;
  assign BUS.core_reset = s.b_core;
  assign SW_RDATA = s.sw_rdata;

endmodule

// ### test/eac_checker.sv
// assertions on the io bus between the cpu side and the eeprom controller
`timescale 1ns/1ps
module eac_checker
  import eac_pkg::*;
#(
  parameter int ATOMIC_CYC = 40,
  parameter int SPLIT_CYC = 20
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] addr,
  input wire logic io_space,
  input wire logic we,
  input wire logic re,
  input wire logic bset,
  input wire logic bclr,
  input wire logic [2:0] bit_idx,
  input wire logic gie,
  input wire logic [7:0] rdata,
  input wire logic stall,
  input wire logic ready_irq,
  input wire logic PROG_ACTIVE,
  input wire logic FLASH_SELFPROG_BUSY
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [17:0] prog_cnt;
  logic ctrl_hit;
  assign ctrl_hit = io_space && addr == {2'b00, IO_CTRL};
  // the host polls the control register through data space
  logic ctrl_ds;
  assign ctrl_ds = !io_space && addr == 8'({2'b00, IO_CTRL}) + DATA_SPACE_OFS;
  // counts busy cycles so the programming time is checked as a whole
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prog_cnt <= 18'h0_0000;
    end else begin
      prog_cnt <= PROG_ACTIVE ? prog_cnt + 18'h0_0001 : 18'h0_0000;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_write_stall;
    stall ##1 stall ##1 !stall;
  endsequence
  sequence s_read_stall;
    stall [*4] ##1 !stall;
  endsequence
  property p_rdata_idle;
    !$past(re) |-> rdata == 8'h00;
  endproperty
  property p_ctrl_top;
    re && (ctrl_hit || ctrl_ds) |=> rdata[7:6] == 2'b00;
  endproperty
  property p_gie_arm;
    we && ctrl_hit |-> !gie;
  endproperty
  property p_read_stall;
    bset && ctrl_hit && bit_idx == 3'(CTRL_READ) && !PROG_ACTIVE |=> s_read_stall;
  endproperty
  property p_write_stall;
    $rose(PROG_ACTIVE) |-> s_write_stall;
  endproperty
  property p_no_issue;
    stall |-> !(we || re || bset || bclr);
  endproperty
  property p_start_strobe;
    $rose(PROG_ACTIVE) |-> $past(bset && ctrl_hit && bit_idx == 3'(CTRL_STROBE));
  endproperty
  property p_no_flash;
    $rose(PROG_ACTIVE) |-> !$past(FLASH_SELFPROG_BUSY);
  endproperty
  property p_irq_busy;
    PROG_ACTIVE && $past(PROG_ACTIVE) |-> !ready_irq;
  endproperty
  property p_irq_gie;
    !gie && !$past(gie) |-> !ready_irq;
  endproperty
  property p_prog_len;
    $fell(PROG_ACTIVE) |-> (prog_cnt >= ATOMIC_CYC - 1 && prog_cnt <= ATOMIC_CYC + 1)
      || (prog_cnt >= SPLIT_CYC - 1 && prog_cnt <= SPLIT_CYC + 1);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  a_ctrl_top: assert property (p_ctrl_top)
    else $error("control top bits not zero");
  a_read_stall: assert property (p_read_stall)
    else $error("read stall not four cycles");
  a_write_stall: assert property (p_write_stall)
    else $error("write stall not two cycles");
  a_no_issue: assert property (p_no_issue)
    else $error("access issued during stall");
  a_start_strobe: assert property (p_start_strobe)
    else $error("programming began without strobe");
  a_no_flash: assert property (p_no_flash)
    else $error("programming began under flash busy");
  a_irq_busy: assert property (p_irq_busy)
    else $error("ready interrupt during programming");
  a_irq_gie: assert property (p_irq_gie)
    else $error("ready interrupt with global flag clear");
  a_prog_len: assert property (p_prog_len)
    else $error("programming time wrong");
  a_gie_arm: assert property (p_gie_arm)
    else $error("global interrupts on while arming");
endmodule

// ### test/eac_tb_top.sv
// self-checking bench joining both ends of the eeprom access controller
`timescale 1ns/1ps
module eac_tb_top;
  import eac_pkg::*;
  localparam int ATOMIC_T = 40;
  localparam int SPLIT_T = 20;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic flash_busy = 1'b0;
  logic prog_active;
  logic [1:0] sw_addr = 2'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_we = 1'b0;
  logic sw_re = 1'b0;
  logic [15:0] sw_rdata;
  logic [15:0] rd_val;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #10 ref_clk = ~ref_clk;
  eac_if bus_if ();
  eac_dev #(.ATOMIC_CYC(ATOMIC_T), .SPLIT_CYC(SPLIT_T)) eac_dev_inst (.REF_CLK(ref_clk),
    .ARST_N(arst_n), .BUS(bus_if), .FLASH_SELFPROG_BUSY(flash_busy),
    .PROG_ACTIVE(prog_active));
  eac_host eac_host_inst (.REF_CLK(ref_clk), .ARST_N(arst_n), .BUS(bus_if),
    .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WE(sw_we), .SW_RE(sw_re),
    .SW_RDATA(sw_rdata));
  eac_checker #(.ATOMIC_CYC(ATOMIC_T), .SPLIT_CYC(SPLIT_T)) eac_checker_inst (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .addr(bus_if.addr), .io_space(bus_if.io_space),
    .we(bus_if.we), .re(bus_if.re), .bset(bus_if.bset), .bclr(bus_if.bclr),
    .bit_idx(bus_if.bit_idx), .gie(bus_if.gie), .rdata(bus_if.rdata),
    .stall(bus_if.stall), .ready_irq(bus_if.ready_irq), .PROG_ACTIVE(prog_active),
    .FLASH_SELFPROG_BUSY(flash_busy));
  // ----------------------------------------------------------------
  // command port tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'b1;
    @(posedge ref_clk);
    sw_we <= 1'b0;
  endtask
  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge ref_clk);
    sw_re <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // polling is bounded so a stuck busy bit ends as a mismatch
  task automatic wait_idle();
    int k;
    k = 0;
    rd_val = 16'h0001;
    while (rd_val[HS_BUSY] !== 1'b0 && k < 300) begin
      sw_rd(HOST_CTRL, rd_val);
      k++;
    end
    check("busy", 16'h0000, {15'h0000, rd_val[HS_BUSY]});
  endtask
  // samples one step after the edge so the flop has settled
  task automatic wait_prog(input logic lvl);
    n = 0;
    while (prog_active !== lvl && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("programming", {15'h0000, lvl}, {15'h0000, prog_active});
  endtask
  task automatic go_write(input logic [8:0] a, input logic [7:0] d, input logic [15:0] c);
    sw_wr(HOST_ADDR, {7'h00, a});
    sw_wr(HOST_DATA, {8'h00, d});
    sw_wr(HOST_CTRL, c | 16'h0001);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic ee_write(input logic [8:0] a, input logic [7:0] d, input logic [15:0] c);
    go_write(a, d, c);
    wait_idle();
  endtask
  task automatic ee_read(input logic [8:0] a, input logic [7:0] exp);
    sw_wr(HOST_ADDR, {7'h00, a});
    sw_wr(HOST_CTRL, 16'h0002);
    repeat (2) @(posedge ref_clk);
    wait_idle();
    sw_rd(HOST_RESULT, rd_val);
    check("eeprom byte", {8'h00, exp}, rd_val);
  endtask
  // ----------------------------------------------------------------
  // timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    sw_rd(HOST_CTRL, rd_val);
    check("status after reset", 16'h0000, rd_val);
    ee_write(9'h1A5, 8'h3C, 16'h0000);
    ee_read(9'h1A5, 8'h3C);
    ee_write(9'h1A5, 8'h0F, 16'h0008);
    ee_read(9'h1A5, 8'h0C);
    ee_write(9'h1A5, 8'h00, 16'h0004);
    ee_read(9'h1A5, 8'hFF);
    ee_write(9'h1A5, 8'h00, 16'h000C);
    ee_read(9'h1A5, 8'hFF);
    ee_write(9'h1FF, 8'h5A, 16'h0000);
    ee_read(9'h1FF, 8'h5A);
    ee_read(9'h1A5, 8'hFF);
    // a second order issued mid-write waits on the busy bit, then lands
    go_write(9'h0F0, 8'hA5, 16'h0000);
    wait_prog(1'b1);
    go_write(9'h1A5, 8'h11, 16'h0000);
    wait_idle();
    ee_read(9'h1A5, 8'h11);
    ee_read(9'h0F0, 8'hA5);
    // ready interrupt: quiet while busy, up when idle, masked by global flag
    go_write(9'h010, 8'h77, 16'h0030);
    wait_prog(1'b1);
    sw_rd(HOST_CTRL, rd_val);
    check("irq busy", 16'h0000, {15'h0000, rd_val[HS_IRQ]});
    wait_idle();
    wait_prog(1'b0);
    repeat (3) @(posedge ref_clk);
    sw_rd(HOST_CTRL, rd_val);
    check("irq idle", 16'h0001, {15'h0000, rd_val[HS_IRQ]});
    sw_wr(HOST_CTRL, 16'h0010);
    repeat (3) @(posedge ref_clk);
    sw_rd(HOST_CTRL, rd_val);
    check("irq masked", 16'h0000, {15'h0000, rd_val[HS_IRQ]});
    // flash self-programming holds the write back until it ends
    flash_busy <= 1'b1;
    go_write(9'h0AA, 8'h96, 16'h0000);
    repeat (200) @(posedge ref_clk);
    check("held by flash", 16'h0000, {15'h0000, prog_active});
    flash_busy <= 1'b0;
    wait_idle();
    ee_read(9'h0AA, 8'h96);
    // cpu reset during programming lets the write finish
    go_write(9'h155, 8'h42, 16'h0000);
    wait_prog(1'b1);
    sw_wr(HOST_CTRL, 16'h0040);
    wait_idle();
    ee_read(9'h155, 8'h42);
    stop_test();
  end
endmodule
